// file: verilog/swfd_cfg.svh
// Purpose: Constants of the single-wire frame decoder: frame layout, codes, timing.
// Assumes: Bit-period ticks come from the symbol layer on the same clock.
// Notes:   Definitions only.
`ifndef SWFD_CFG_SVH
`define SWFD_CFG_SVH

// ****************************************************************
// Instruction frame layout, bit 0 arrives first.
// ****************************************************************
`define SWFD_FRAME_BITS 5'h10
`define SWFD_CS_POS     0
`define SWFD_OP_LSB     1
`define SWFD_BANK_LSB   3
`define SWFD_ADDR_LSB   5
`define SWFD_CNT_LSB    13
`define SWFD_BYTE_BITS  4'h8

// ****************************************************************
// Operation and bank codes and the chip-address bit.
// ****************************************************************
`define SWFD_OP_WRITE   2'h0
`define SWFD_OP_READ    2'h1
`define SWFD_OP_READCRC 2'h2
`define SWFD_OP_SLEEP   2'h3
`define SWFD_BANK_OTP   2'h0
`define SWFD_BANK_CTRL  2'h1
`define SWFD_BANK_AUTH  2'h2
`define SWFD_BANK_TEST  2'h3
`define SWFD_CHIP_ADDR_BIT 6

// ****************************************************************
// Timing in bit periods and the check-byte generator.
// ****************************************************************
`define SWFD_DEVICE_TURNAROUND 2'h1
`define SWFD_DEVICE_FRAME_GAP  2'h1
`define SWFD_CRC_POLY_REV  8'h8C
`define SWFD_CRC_INIT      8'h00

`endif

// file: verilog/swfd_pkg.sv
// Purpose: Types shared by the single-wire frame decoder.
// Assumes: Field widths are those of the 16-bit instruction frame.
// Notes:   Constants live in swfd_cfg.svh.
`default_nettype none
package swfd_pkg;

    // ****************************************************************
    // Types.
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_WDATA, ST_GAP, ST_FETCH, ST_CAP, ST_SEND
    } swfd_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] addr;
        logic [1:0] bank;
        logic [1:0] op;
        logic       cs;
    } swfd_instr_t;

    typedef struct packed {
        logic       we;
        logic       re;
        logic [1:0] bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } swfd_mem_t;

    typedef struct packed {
        swfd_state_t st;
        logic [15:0] sh;
        logic [4:0]  cnt;
        logic [1:0]  op;
        logic [4:0]  left;
        logic [7:0]  crc;
        logic        crcPhase;
        logic [1:0]  gap;
        logic        mute;
        logic        sleep;
        logic        err;
        swfd_mem_t   mem;
    } swfd_regs_t;

endpackage
`default_nettype wire

// file: verilog/swfd_frame_decoder.sv
// Purpose: Slave transaction logic of a single-wire pulse-coded bus.
// Assumes: A symbol layer on clk delivers bits, breaks and bit ticks.
// Notes:   Memory reads are combinational while mem.re is high.
//
// What this block does
// - Each transaction opens with a sixteen-bit instruction frame from the host.
// - Chip-select mismatch ignores the frame and all later frames until a break.
// - Chip address comes from configuration byte bit 6, factory zero.
// - Two-bit operation field selects the transaction after the frame.
// - 00 write, 01 read, 10 read with check byte, 11 sleep at once.
// - Bank: 00 OTP, 01 control/status, 10 authentication, 11 test.
// - Test bank access outside factory test mode raises a bus error.
// - Byte count counts data bytes only, never the check byte.
// - Byte counts 0, 3, 5 and 6 are invalid and raise a bus error, except in a sleep frame.
// - Count 1 means one byte, register banks only.
// - Count 7 means sixteen bytes, OTP read before lock only.
// - Device waits one bit period before replying and between bytes.
// - Only operation 10 appends an 8-bit check over the read data.
// - Check generator is one plus x^4, x^5 and x^8.
// - Check register clears before each calculation, absorbs each sent data bit.
// - Final check register is sent after the data, LSB first.
// - All frames are serialised least significant bit first.
`timescale 1ns/1ps
`default_nettype none
`include "swfd_cfg.svh"

module swfd_frame_decoder
    import swfd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       en,
    input  wire logic       bitTick,
    input  wire logic       rxValid,
    input  wire logic       rxBit,
    input  wire logic       rxBreak,
    input  wire logic       txReady,
    input  wire logic [7:0] cfgByte,
    input  wire logic       testMode,
    input  wire logic       otpLocked,
    input  wire logic [7:0] rdData,
    output var  swfd_mem_t  mem,
    output logic            txValid,
    output logic            txBit,
    output logic            sleepReq,
    output logic            busErr
);

    // ****************************************************************
    // Decoding helpers.
    // ****************************************************************

    // Splits a received frame into its fields, bit 0 first on the wire.
    function automatic swfd_instr_t split(input logic [15:0] f);
        swfd_instr_t i;
        i.cs   = f[`SWFD_CS_POS];
        i.op   = f[`SWFD_OP_LSB +: 2];
        i.bank = f[`SWFD_BANK_LSB +: 2];
        i.addr = f[`SWFD_ADDR_LSB +: 8];
        i.cnt  = f[`SWFD_CNT_LSB +: 3];
        return i;
    endfunction

    // Maps a byte-count code to bytes; invalid codes give zero.
    function automatic logic [4:0] bytesOf(input logic [2:0] c);
        logic [4:0] n;
        n = 5'h00;
        // Only the four legal codes map to a byte count; every other code is zero.
        unique case (c)
            3'h1: n = 5'h01;
            3'h2: n = 5'h02;
            3'h4: n = 5'h04;
            3'h7: n = 5'h10;
            default: n = 5'h00;
        endcase
        return n;
    endfunction

    // True when the instruction may not run; sleep needs no count.
    function automatic logic badInstr(input swfd_instr_t i, input logic tm,
                                      input logic lk);
        logic bad;
        logic rd;
        rd  = (i.op == `SWFD_OP_READ) || (i.op == `SWFD_OP_READCRC);
        bad = (bytesOf(i.cnt) == 5'h00);
        if (i.bank == `SWFD_BANK_TEST && !tm) begin
            bad = 1'b1;
        end
        if (i.cnt == 3'h1 && i.bank == `SWFD_BANK_OTP) begin
            bad = 1'b1;
        end
        if (i.cnt == 3'h7 && !(rd && i.bank == `SWFD_BANK_OTP && !lk)) begin
            bad = 1'b1;
        end
        // Sleep stops at once, so its count and bank fields carry no meaning.
        if (i.op == `SWFD_OP_SLEEP) begin
            bad = 1'b0;
        end
        return bad;
    endfunction

    // ****************************************************************
    // State.
    // ****************************************************************
    swfd_regs_t  s_q;
    swfd_regs_t  s_d;
    swfd_instr_t ins;
    logic [7:0]  crcNext;
    logic        txFire;
    logic        chipAddr;

    // The chip address is read live so a reprogrammed value takes effect.
    assign chipAddr = cfgByte[`SWFD_CHIP_ADDR_BIT];
    // The split sees the bit arriving now, so the sixteenth bit is decided on
    // its own edge and no extra cycle is spent on decoding.
    assign ins      = split({rxBit, s_q.sh[15:1]});
    assign txFire   = (s_q.st == ST_SEND) && txReady;

    // One step of the reflected check register for the bit leaving now.
    // The reflected form lets bits enter LSB first with no reordering.
    assign crcNext = s_q.crc[0] ^ s_q.sh[0] ?
                     (s_q.crc >> 1) ^ `SWFD_CRC_POLY_REV :
                     (s_q.crc >> 1);

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************

    // A read walks GAP, FETCH, CAP and SEND once for every byte. GAP waits
    // for one bit tick, which is the device turnaround before the first byte
    // and the device frame gap before each later one. FETCH raises the read
    // strobe, CAP loads the byte that the memory shows while the strobe
    // stands, and SEND gives out one bit per accepted offer.
    // The check byte reuses GAP and SEND with crcPhase set, so it needs no
    // sender of its own and always follows the last data byte.
    //
    // A write stays in WDATA until the last byte has landed. Every eighth
    // bit raises the write strobe for one cycle with the byte taken from the
    // top of the shift register.
    //
    // Ignored frames are handled by the mute flag: the bit counter stands
    // still while it is set, so only a break brings framing back. The cost
    // is that a host which lost count of its bits must send a break before
    // it can talk to this device again.
    //
    // Single process keeps all transitions and pulses in one place.
    always_comb begin
        s_d        = s_q;
        s_d.sleep  = 1'b0;
        s_d.err    = 1'b0;
        s_d.mem.we = 1'b0;
        s_d.mem.re = 1'b0;
        // Address steps only after the access that used it.
        // This keeps mem.addr steady while a strobe stands.
        if (s_q.mem.we || s_q.mem.re) begin
            s_d.mem.addr = s_q.mem.addr + 8'h01;
        end
        unique case (s_q.st)
            // Collect instruction bits; the sixteenth decides what follows.
            ST_IDLE: begin
                if (rxValid && !s_q.mute) begin
                    s_d.sh  = {rxBit, s_q.sh[15:1]};
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.cnt == `SWFD_FRAME_BITS - 5'h01) begin
                        s_d.cnt      = 5'h00;
                        s_d.op       = ins.op;
                        s_d.mem.bank = ins.bank;
                        s_d.mem.addr = ins.addr;
                        s_d.left     = bytesOf(ins.cnt);
                        s_d.crc      = `SWFD_CRC_INIT;
                        s_d.crcPhase = 1'b0;
                        if (ins.cs != chipAddr) begin
                            s_d.mute = 1'b1;
                        end else if (badInstr(ins, testMode, otpLocked)) begin
                            s_d.err  = 1'b1;
                            s_d.mute = 1'b1;
                        end else begin
                            unique case (ins.op)
                                `SWFD_OP_WRITE: s_d.st = ST_WDATA;
                                `SWFD_OP_SLEEP: begin
                                    s_d.sleep = 1'b1;
                                    s_d.mute  = 1'b1;
                                end
                                default: begin
                                    s_d.st  = ST_GAP;
                                    s_d.gap = `SWFD_DEVICE_TURNAROUND;
                                end
                            endcase
                        end
                    end
                end
            end
            // Write bytes arrive as plain data bits after the frame.
            ST_WDATA: begin
                if (rxValid) begin
                    s_d.sh  = {rxBit, s_q.sh[15:1]};
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.cnt[3:0] == `SWFD_BYTE_BITS - 4'h1) begin
                        s_d.cnt       = 5'h00;
                        s_d.mem.we    = 1'b1;
                        s_d.mem.wdata = {rxBit, s_q.sh[15:9]};
                        s_d.left      = s_q.left - 5'h01;
                        if (s_q.left == 5'h01) begin
                            s_d.st = ST_IDLE;
                        end
                    end
                end
            end
            // Turnaround and inter-byte gap both count bit ticks here.
            ST_GAP: begin
                if (bitTick) begin
                    s_d.gap = s_q.gap - 2'h1;
                    if (s_q.gap == 2'h1) begin
                        s_d.st = s_q.crcPhase ? ST_SEND : ST_FETCH;
                    end
                end
            end
            // One cycle to raise the read strobe.
            ST_FETCH: begin
                s_d.mem.re = 1'b1;
                s_d.st     = ST_CAP;
            end
            // The memory answers while the strobe stands, so the byte is taken
            // here and not one cycle later.
            ST_CAP: begin
                s_d.sh  = {8'h00, rdData};
                s_d.cnt = 5'h00;
                s_d.st  = ST_SEND;
            end
            // One bit leaves per accepted offer. The check absorbs data bits
            // only, never the bits of the check byte itself.
            ST_SEND: begin
                if (txFire) begin
                    s_d.sh  = {1'b0, s_q.sh[15:1]};
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (!s_q.crcPhase) begin
                        s_d.crc = crcNext;
                    end
                    if (s_q.cnt[3:0] == `SWFD_BYTE_BITS - 4'h1) begin
                        s_d.cnt  = 5'h00;
                        s_d.gap  = `SWFD_DEVICE_FRAME_GAP;
                        s_d.left = s_q.crcPhase ? s_q.left : s_q.left - 5'h01;
                        if (s_q.crcPhase) begin
                            s_d.st = ST_IDLE;
                        end else if (s_q.left != 5'h01) begin
                            s_d.st = ST_GAP;
                        end else if (s_q.op == `SWFD_OP_READCRC) begin
                            s_d.st       = ST_GAP;
                            s_d.crcPhase = 1'b1;
                            s_d.sh       = {8'h00, crcNext};
                        end else begin
                            s_d.st = ST_IDLE;
                        end
                    end
                end
            end
        endcase
        // A break restarts framing from any state and lifts the mute.
        // It comes last so that it wins over any transition of the same cycle.
        if (rxBreak) begin
            s_d.st       = ST_IDLE;
            s_d.cnt      = 5'h00;
            s_d.mute     = 1'b0;
            s_d.mem.we   = 1'b0;
            s_d.mem.re   = 1'b0;
            s_d.crcPhase = 1'b0;
        end
    end

    // ****************************************************************
    // Registers and outputs.
    // ****************************************************************

    // Clock enable freezes everything, pulses included.
    // The far side must hold its offers while en is low, as a frozen cycle
    // takes no bit and gives none.
    // An all-zero reset leaves the machine idle and unmuted.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else if (en) begin
            s_q <= s_d;
        end
    end

    // Handshake is decoded from state; data comes from flops.
    // txValid is combinational so the encoder sees a new byte without delay.
    assign txValid  = (s_q.st == ST_SEND);
    assign txBit    = s_q.sh[0];
    assign mem      = s_q.mem;
    assign sleepReq = s_q.sleep;
    assign busErr   = s_q.err;

endmodule
`default_nettype wire

// file: verif/swfd_frame_decoder_props.sv
// Purpose: Port-level checks of the single-wire frame decoder.
// Assumes: One clock; en low freezes state, so checks pause with it.
// Notes:   Bound to every instance of swfd_frame_decoder.
`timescale 1ns/1ps
`default_nettype none
module swfd_frame_decoder_props
    import swfd_pkg::*;
(
    input wire logic      clk,
    input wire logic      nrst,
    input wire logic      en,
    input wire logic      txReady,
    input wire logic      testMode,
    input wire swfd_mem_t mem,
    input wire logic      txValid,
    input wire logic      txBit,
    input wire logic      sleepReq,
    input wire logic      busErr
);
    // ****************************************************************
    // Assertions.
    // ****************************************************************
    // Frozen enable stretches pulses, so a pulse check must not run then.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !en);

    we_pulse_a: assert property (mem.we |=> !mem.we) else $error("write strobe too long");
    addr_step_a: assert property (mem.we |=> mem.addr == $past(mem.addr) + 8'h01)
        else $error("address did not step after a write");
    one_op_a: assert property (mem.we |-> !mem.re && !txValid) else $error("write overlaps read");
    re_send_a: assert property (mem.re |=> txValid) else $error("no send after fetch");
    tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txBit))
        else $error("send bit changed before acceptance");
    err_quiet_a: assert property (busErr |-> !mem.we && !mem.re && !txValid)
        else $error("bus error with data activity");
    err_pulse_a: assert property (busErr |=> !busErr) else $error("bus error not a pulse");
    sleep_pulse_a: assert property (sleepReq |=> !sleepReq) else $error("sleep not a pulse");
    test_bank_a: assert property ((mem.we || mem.re) && !testMode |-> mem.bank != 2'h3)
        else $error("test bank reached outside test mode");

    cover property (mem.we ##1 mem.addr != 8'h00);
    cover property (mem.re ##1 txValid);
    cover property (busErr);
    cover property (sleepReq);
endmodule

bind swfd_frame_decoder swfd_frame_decoder_props i_swfd_frame_decoder_props (
    .clk(clk), .nrst(nrst), .en(en), .txReady(txReady), .testMode(testMode), .mem(mem),
    .txValid(txValid), .txBit(txBit), .sleepReq(sleepReq), .busErr(busErr));
`default_nettype wire

// file: verif/swfd_host_model.sv
// Purpose: Far side of the decoder: bit-period source and slow bit taker.
// Assumes: Inputs change just after the rising edge.
// Notes:   Received bits collect in the queue got, first sent first.
`timescale 1ns/1ps
`default_nettype none
module swfd_host_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic txValid,
    input  wire logic txBit,
    output logic      bitTick,
    output logic      txReady
);
    logic [1:0] div;
    logic       got[$];

    // A bit period of four clocks keeps runs short; one bit is taken per period.
    always @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            div <= 2'h0;
            bitTick <= 1'b0;
            txReady <= 1'b0;
        end else begin
            div <= div + 2'h1;
            bitTick <= (div == 2'h3);
            txReady <= txValid && (div == 2'h1);
        end
    end

    // Bits are stored in wire order, so byte assembly reads them LSB first.
    always @(posedge clk) begin
        if (txValid && txReady) got.push_back(txBit);
    end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench of the single-wire frame decoder.
// Assumes: Inputs move at the falling edge; read data is addr xor bank xor 5A.
// Notes:   Each error case is followed by a break to leave the muted state.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import swfd_pkg::*;
    logic        clk, nrst, en, rxValid, rxBit, rxBreak, testMode, otpLocked;
    logic        bitTick, txReady, txValid, txBit, sleepReq, busErr;
    logic [7:0]  cfgByte, rdData, b, crc;
    swfd_mem_t   mem;
    int          miscompares, n_tests, errs, sleeps, e;
    logic [15:0] wq[$];
    logic [6:0]  bad[7] = '{7'h08, 7'h0B, 7'h0D, 7'h0E, 7'h1A, 7'h21, 7'h27};

    swfd_frame_decoder i_swfd_frame_decoder (.clk(clk), .nrst(nrst), .en(en),
        .bitTick(bitTick), .rxValid(rxValid), .rxBit(rxBit), .rxBreak(rxBreak),
        .txReady(txReady), .cfgByte(cfgByte), .testMode(testMode), .otpLocked(otpLocked),
        .rdData(rdData), .mem(mem), .txValid(txValid), .txBit(txBit),
        .sleepReq(sleepReq), .busErr(busErr));
    swfd_host_model i_swfd_host_model (.clk(clk), .nrst(nrst), .txValid(txValid),
        .txBit(txBit), .bitTick(bitTick), .txReady(txReady));

    // Outside a fetch the data lines show the inverse, so a late sample fails.
    // The bank is folded in so that a wrong bank shows up in the data.
    assign rdData = mem.re ? (mem.addr ^ {6'h00, mem.bank} ^ 8'h5A) :
                    ~(mem.addr ^ {6'h00, mem.bank} ^ 8'h5A);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Event log of pulses and write strobes.
    always @(posedge clk) begin
        if (busErr === 1'b1) errs++;
        if (sleepReq === 1'b1) sleeps++;
        if (mem.we === 1'b1) wq.push_back({mem.addr, mem.wdata});
    end

    task checkV(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Host frames go out LSB first, one bit per clock, with one idle clock after each.
    task sendBits(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rxValid = 1'b1;
            rxBit = v[i];
        end
        @(negedge clk);
        rxValid = 1'b0;
    endtask

    task frame(input logic [1:0] op, bank, input logic [7:0] a, input logic [2:0] n, input logic cs);
        swfd_instr_t f;
        f = '{cnt: n, addr: a, bank: bank, op: op, cs: cs};
        sendBits(f, 16);
    endtask

    task brk;
        @(negedge clk);
        rxBreak = 1'b1;
        @(negedge clk);
        rxBreak = 1'b0;
    endtask

    task waitBits(input int n);
        for (int i = 0; i < 2000 && i_swfd_host_model.got.size() < n; i++) @(negedge clk);
        repeat (4) @(negedge clk);
    endtask

    task getByte(output logic [7:0] v);
        for (int i = 0; i < 8; i++) v[i] = i_swfd_host_model.got.pop_front();
    endtask

    function automatic logic [7:0] crcByte(input logic [7:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
        return c;
    endfunction

    task results;
        $display("Tests %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #200us;
        miscompares++;
        results();
    end

    initial begin
        {nrst, rxValid, rxBit, rxBreak, testMode, otpLocked} = 6'h00;
        cfgByte = 8'h00;
        en = 1'b1;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        brk();
        frame(2'h0, 2'h1, 8'h10, 3'h2, 1'b0);
        sendBits(16'hA13C, 16);
        repeat (20) @(negedge clk);
        checkV(wq.size(), 2);
        checkV(wq.pop_front(), 16'h103C);
        checkV(wq.pop_front(), 16'h11A1);
        frame(2'h2, 2'h0, 8'h01, 3'h2, 1'b0);
        waitBits(24);
        crc = 8'h00;
        for (int i = 1; i < 3; i++) begin
            getByte(b);
            checkV(b, 8'(i) ^ 8'h5A);
            crc = crcByte(crc, 8'(i) ^ 8'h5A);
        end
        getByte(b);
        checkV(b, crc);
        frame(2'h1, 2'h2, 8'h05, 3'h1, 1'b0);
        waitBits(9);
        checkV(i_swfd_host_model.got.size(), 8);
        getByte(b);
        checkV(b, 8'h5D);
        frame(2'h1, 2'h0, 8'h01, 3'h7, 1'b0);
        waitBits(129);
        checkV(i_swfd_host_model.got.size(), 128);
        for (int i = 0; i < 16; i++) getByte(b);
        checkV(b, 8'h4A);
        otpLocked = 1'b1;
        foreach (bad[k]) begin
            e = errs;
            frame(bad[k][6:5], bad[k][4:3], 8'h01, bad[k][2:0], 1'b0);
            repeat (4) @(negedge clk);
            checkV(errs - e, 1);
            brk();
        end
        e = sleeps;
        frame(2'h3, 2'h1, 8'h00, 3'h0, 1'b0);
        repeat (4) @(negedge clk);
        checkV(sleeps - e, 1);
        brk();
        cfgByte = 8'h40;
        frame(2'h0, 2'h1, 8'h20, 3'h1, 1'b0);
        sendBits(16'h0077, 8);
        frame(2'h0, 2'h1, 8'h20, 3'h1, 1'b1);
        sendBits(16'h0077, 8);
        repeat (20) @(negedge clk);
        checkV(wq.size(), 0);
        brk();
        // A frame offered while en is low must leave no trace.
        en = 1'b0;
        frame(2'h0, 2'h1, 8'h30, 3'h1, 1'b1);
        sendBits(16'h0099, 8);
        en = 1'b1;
        frame(2'h0, 2'h1, 8'h21, 3'h1, 1'b1);
        sendBits(16'h0055, 8);
        repeat (20) @(negedge clk);
        checkV(wq.size(), 1);
        checkV(wq.pop_front(), 16'h2155);
        testMode = 1'b1;
        e = errs;
        frame(2'h0, 2'h3, 8'h40, 3'h1, 1'b1);
        sendBits(16'h0066, 8);
        repeat (20) @(negedge clk);
        checkV(errs - e, 0);
        checkV(wq.pop_front(), 16'h4066);
        results();
    end
endmodule
`default_nettype wire
